// ===== hdl/board_mode_sequencer.v
// Contract
// - Triggered configuration runs to completion unaided
// - Only this controller changes board state
// - Read identity and calibration data from EEPROM (code reads only identity number and revision)
// - Config directory name is identity plus revision
// - No matching directory: abort to standby
// - Standby unpowered; only powerup reaches operating
// - Operating keeps peripherals, clocks, processors on
// - Powerdown goes to standby, sleep to sleep
// - Sleep powers clusters off, retains data
// - Sleep never goes directly to standby
// - Powerdown starts only from operating state
// - Long button hold in operating powers down
// - Short press in operating starts sleep
// - Short press in sleep wakes board
`timescale 1ns/1ns
`include "board_mode_sequencer_defs.vh"

module board_mode_sequencer #(
  parameter HOLD_CYCLES = `HOLD_CYCLES,
  parameter ACK_TIMEOUT = `ACK_TIMEOUT_CYCLES
) (
  input  wire                 mclk_i,
  input  wire                 reset_n_i,
  input  wire                 power_applied_i,
  input  wire                 onoff_btn_i,
  input  wire                 hw_reset_btn_i,
  input  wire                 os_pwrdn_req_i,
  output reg                  eeprom_rd_o,
  input  wire                 eeprom_done_i,
  input  wire [`ID_NUM_W-1:0] board_identity_number_i,
  input  wire [`ID_REV_W-1:0] board_rev_i,
  output reg                  card_search_o,
  output reg  [`ID_NUM_W+`ID_REV_W-1:0] card_dir_name_o,
  input  wire                 card_done_i,
  input  wire                 card_match_i,
  output reg                  board_power_en_o,
  output reg                  clocks_en_o,
  output reg                  cluster_power_en_o,
  output reg                  retention_en_o,
  output reg                  sys_reset_n_o,
  output reg                  cluster_sleep_req_o,
  input  wire                 cluster_ack_i,
  output reg                  config_fail_o,
  output reg  [1:0]           board_mode_o
);

  // ****************************************************************
  // States
  // ****************************************************************
  localparam [3:0] ST_STANDBY  = 4'h0;
  localparam [3:0] ST_EEPROM   = 4'h1;
  localparam [3:0] ST_SEARCH   = 4'h2;
  localparam [3:0] ST_POWERUP  = 4'h3;
  localparam [3:0] ST_OPER     = 4'h4;
  localparam [3:0] ST_PWRDN    = 4'h5;
  localparam [3:0] ST_SLEEPING = 4'h6;
  localparam [3:0] ST_SLEEP    = 4'h7;
  localparam [3:0] ST_WAKE     = 4'h8;

  reg [3:0]  state_r;
  reg [3:0]  state_nxt;
  reg [31:0] hold_cnt_r;
  reg [31:0] wait_cnt_r;
  reg        btn_d_r;
  reg        pwr_d_r;
  reg        long_seen_r;
  reg        pd_pending_r;

  wire btn_rise  = onoff_btn_i & ~btn_d_r;
  wire btn_fall  = ~onoff_btn_i & btn_d_r;
  wire pwr_rise  = power_applied_i & ~pwr_d_r;
  wire long_hold = onoff_btn_i && (hold_cnt_r >= HOLD_CYCLES - 32'h1);
  wire short_rel = btn_fall && !long_seen_r;
  // Powerdown remembered from sleep is acted on once operating
  wire pd_req    = hw_reset_btn_i | os_pwrdn_req_i | long_hold | pd_pending_r;
  wire wait_out  = (wait_cnt_r >= ACK_TIMEOUT - 32'h1);
  wire ack_done  = cluster_ack_i | wait_out;

  // ****************************************************************
  // Decode helpers
  // ****************************************************************
  // Saturating step so a stuck input never wraps a timer
  function [31:0] sat_inc;
    input [31:0] cnt;
    input        at_limit;
    begin
      if (at_limit)
        sat_inc = cnt;
      else
        sat_inc = cnt + 32'h1;
    end
  endfunction

  // Board supply stays off until a match is found
  function board_power_on;
    input [3:0] st;
    begin
      case (st)
        ST_STANDBY: board_power_on = 1'b0;
        ST_EEPROM:  board_power_on = 1'b0;
        ST_SEARCH:  board_power_on = 1'b0;
        default:    board_power_on = 1'b1;
      endcase
    end
  endfunction

  // Clocks stop in standby, config steps and sleep
  function clocks_on;
    input [3:0] st;
    begin
      case (st)
        ST_POWERUP:  clocks_on = 1'b1;
        ST_OPER:     clocks_on = 1'b1;
        ST_PWRDN:    clocks_on = 1'b1;
        ST_SLEEPING: clocks_on = 1'b1;
        ST_WAKE:     clocks_on = 1'b1;
        default:     clocks_on = 1'b0;
      endcase
    end
  endfunction

  // Clusters powered only while they run code
  function cluster_on;
    input [3:0] st;
    begin
      case (st)
        ST_POWERUP: cluster_on = 1'b1;
        ST_OPER:    cluster_on = 1'b1;
        ST_WAKE:    cluster_on = 1'b1;
        default:    cluster_on = 1'b0;
      endcase
    end
  endfunction

  // Retention held from sleep entry until wake completes
  function retain_on;
    input [3:0] st;
    begin
      case (st)
        ST_SLEEPING: retain_on = 1'b1;
        ST_SLEEP:    retain_on = 1'b1;
        ST_WAKE:     retain_on = 1'b1;
        default:     retain_on = 1'b0;
      endcase
    end
  endfunction

  // System reset released from operating until powerdown ends
  function sys_run;
    input [3:0] st;
    begin
      case (st)
        ST_OPER:     sys_run = 1'b1;
        ST_PWRDN:    sys_run = 1'b1;
        ST_SLEEPING: sys_run = 1'b1;
        ST_SLEEP:    sys_run = 1'b1;
        ST_WAKE:     sys_run = 1'b1;
        default:     sys_run = 1'b0;
      endcase
    end
  endfunction

  // Clusters asked to shut down for sleep or powerdown
  function sleep_req;
    input [3:0] st;
    begin
      case (st)
        ST_SLEEPING: sleep_req = 1'b1;
        ST_PWRDN:    sleep_req = 1'b1;
        default:     sleep_req = 1'b0;
      endcase
    end
  endfunction

  // Every transient state reports busy
  function [1:0] mode_code;
    input [3:0] st;
    begin
      case (st)
        ST_STANDBY: mode_code = `MODE_STANDBY;
        ST_OPER:    mode_code = `MODE_OPERATING;
        ST_SLEEP:   mode_code = `MODE_SLEEP;
        default:    mode_code = `MODE_BUSY;
      endcase
    end
  endfunction

  // ****************************************************************
  // Button timing
  // ****************************************************************
  always @(posedge mclk_i) begin
    if (!reset_n_i) begin
      btn_d_r     <= 1'b0;
      pwr_d_r     <= 1'b0;
      hold_cnt_r  <= 32'h0;
      long_seen_r <= 1'b0;
    end else begin
      btn_d_r <= onoff_btn_i;
      pwr_d_r <= power_applied_i;
      if (!onoff_btn_i) begin
        hold_cnt_r  <= 32'h0;
        long_seen_r <= 1'b0;
      end else begin
        hold_cnt_r <= sat_inc(hold_cnt_r, long_hold);
        if (long_hold)
          long_seen_r <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_STANDBY: begin
        if (pwr_rise || btn_rise)
          state_nxt = ST_EEPROM;
      end
      ST_EEPROM: begin
        if (eeprom_done_i)
          state_nxt = ST_SEARCH;
      end
      ST_SEARCH: begin
        if (card_done_i)
          state_nxt = card_match_i ? ST_POWERUP : ST_STANDBY;
      end
      ST_POWERUP: begin
        if (ack_done)
          state_nxt = ST_OPER;
      end
      ST_OPER: begin
        if (pd_req)
          state_nxt = ST_PWRDN;
        else if (short_rel)
          state_nxt = ST_SLEEPING;
      end
      ST_PWRDN: begin
        if (ack_done)
          state_nxt = ST_STANDBY;
      end
      ST_SLEEPING: begin
        if (ack_done)
          state_nxt = ST_SLEEP;
      end
      ST_SLEEP: begin
        if (short_rel || pd_pending_r || hw_reset_btn_i || os_pwrdn_req_i)
          state_nxt = ST_WAKE;
      end
      ST_WAKE: begin
        if (ack_done)
          state_nxt = ST_OPER;
      end
      default: state_nxt = ST_STANDBY;
    endcase
  end

  // ****************************************************************
  // State and outputs
  // ****************************************************************
  always @(posedge mclk_i) begin
    if (!reset_n_i) begin
      state_r             <= ST_STANDBY;
      wait_cnt_r          <= 32'h0;
      pd_pending_r        <= 1'b0;
      eeprom_rd_o         <= 1'b0;
      card_search_o       <= 1'b0;
      card_dir_name_o     <= {(`ID_NUM_W+`ID_REV_W){1'b0}};
      board_power_en_o    <= 1'b0;
      clocks_en_o         <= 1'b0;
      cluster_power_en_o  <= 1'b0;
      retention_en_o      <= 1'b0;
      sys_reset_n_o       <= 1'b0;
      cluster_sleep_req_o <= 1'b0;
      config_fail_o       <= 1'b0;
      board_mode_o        <= `MODE_STANDBY;
    end else begin
      state_r <= state_nxt;
      if (state_nxt != state_r)
        wait_cnt_r <= 32'h0;
      else
        wait_cnt_r <= sat_inc(wait_cnt_r, wait_out);
      // Powerdown asked in sleep is replayed once operating
      if (state_r == ST_SLEEP && (hw_reset_btn_i || os_pwrdn_req_i))
        pd_pending_r <= 1'b1;
      else if (state_r == ST_OPER)
        pd_pending_r <= 1'b0;
      if (state_r == ST_EEPROM && eeprom_done_i)
        card_dir_name_o <= {board_identity_number_i, board_rev_i};
      if (state_r == ST_SEARCH && card_done_i)
        config_fail_o <= !card_match_i;
      eeprom_rd_o         <= (state_nxt == ST_EEPROM);
      card_search_o       <= (state_nxt == ST_SEARCH);
      board_power_en_o    <= board_power_on(state_nxt);
      clocks_en_o         <= clocks_on(state_nxt);
      cluster_power_en_o  <= cluster_on(state_nxt);
      retention_en_o      <= retain_on(state_nxt);
      sys_reset_n_o       <= sys_run(state_nxt);
      cluster_sleep_req_o <= sleep_req(state_nxt);
      board_mode_o        <= mode_code(state_nxt);
    end
  end

endmodule // board_mode_sequencer

// ===== hdl/board_mode_sequencer_defs.vh
`ifndef BOARD_MODE_SEQUENCER_DEFS_VH
`define BOARD_MODE_SEQUENCER_DEFS_VH

// ****************************************************************
// Timing
// ****************************************************************
`define HOLD_TIME_MS       32'h7d0
`define CLK_KHZ            32'h61a8
`define HOLD_CYCLES        (`HOLD_TIME_MS * `CLK_KHZ)
`define ACK_TIMEOUT_CYCLES 32'hf4240

// ****************************************************************
// Board mode encoding
// ****************************************************************
`define MODE_STANDBY   2'h0
`define MODE_OPERATING 2'h1
`define MODE_SLEEP     2'h2
`define MODE_BUSY      2'h3

// ****************************************************************
// Identity record layout
// ****************************************************************
`define ID_NUM_W  16
`define ID_REV_W  8

`endif

// ===== testbench/board_mode_sequencer_chk.sv
`timescale 1ns/1ns
`include "board_mode_sequencer_defs.vh"
module board_mode_sequencer_chk (
  input wire        mclk_i,
  input wire        reset_n_i,
  input wire        eeprom_rd_o,
  input wire [15:0] board_identity_number_i,
  input wire [7:0]  board_rev_i,
  input wire        card_search_o,
  input wire [23:0] card_dir_name_o,
  input wire        card_done_i,
  input wire        card_match_i,
  input wire        board_power_en_o,
  input wire        clocks_en_o,
  input wire        cluster_power_en_o,
  input wire        retention_en_o,
  input wire        sys_reset_n_o,
  input wire        cluster_sleep_req_o,
  input wire        config_fail_o,
  input wire [1:0]  board_mode_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);
  sleep_no_standby_a: assert property (board_mode_o == `MODE_SLEEP |=>
    board_mode_o != `MODE_STANDBY) else $error("sleep went to standby");
  config_start_a: assert property ($rose(eeprom_rd_o) |->
    $past(board_mode_o) == `MODE_STANDBY) else $error("config started outside standby");
  dir_name_a: assert property ($rose(card_search_o) |->
    card_dir_name_o == $past({board_identity_number_i, board_rev_i})) else $error("bad dir name");
  no_match_a: assert property (card_search_o && card_done_i && !card_match_i |=>
    board_mode_o == `MODE_STANDBY && config_fail_o) else $error("no match not aborted");
  operating_on_a: assert property (board_mode_o == `MODE_OPERATING |->
    board_power_en_o && clocks_en_o && cluster_power_en_o && sys_reset_n_o) else $error("op off");
  standby_off_a: assert property (board_mode_o == `MODE_STANDBY |->
    !board_power_en_o && !cluster_power_en_o) else $error("standby powered");
  sleep_retain_a: assert property (board_mode_o == `MODE_SLEEP |->
    retention_en_o && !cluster_power_en_o) else $error("sleep not retaining");
  shutdown_start_a: assert property ($rose(cluster_sleep_req_o) |->
    $past(board_mode_o) == `MODE_OPERATING) else $error("shutdown outside operating");
endmodule // board_mode_sequencer_chk
bind board_mode_sequencer board_mode_sequencer_chk chk (.mclk_i, .reset_n_i, .eeprom_rd_o,
  .board_identity_number_i, .board_rev_i, .card_search_o, .card_dir_name_o, .card_done_i,
  .card_match_i, .board_power_en_o, .clocks_en_o, .cluster_power_en_o, .retention_en_o,
  .sys_reset_n_o, .cluster_sleep_req_o, .config_fail_o, .board_mode_o);

// ===== testbench/board_partner.sv
`timescale 1ns/1ns
module board_partner #(
  parameter [23:0] ID_REC = 24'h1a2b3c // Arbitrary identity and revision
) (
  input  wire        mclk_i,
  input  wire        eeprom_rd_i,
  input  wire        card_search_i,
  input  wire [1:0]  mode_i,
  input  wire        match_en_i,
  input  wire [3:0]  dly_i,
  output wire        eeprom_done_o,
  output wire [23:0] id_rec_o,
  output wire        card_done_o,
  output wire        card_match_o,
  output wire        cluster_ack_o
);
  reg  [3:0] cnt_r = 4'h0;
  wire       hit = (cnt_r == dly_i);
  always @(posedge mclk_i) begin
    cnt_r <= (mode_i == 2'h3 && !hit) ? cnt_r + 4'h1 : 4'h0;
  end
  assign eeprom_done_o = hit && eeprom_rd_i;
  assign id_rec_o      = eeprom_done_o ? ID_REC : ~ID_REC;
  assign card_done_o   = hit && card_search_i;
  assign card_match_o  = card_done_o ? match_en_i : ~match_en_i;
  assign cluster_ack_o = hit && !eeprom_rd_i && !card_search_i;
endmodule // board_partner

// ===== testbench/tb.sv
`timescale 1ns/1ns
module tb;
  reg         mclk_i = 0, reset_n_i = 0, pwr = 0, btn = 0, hrst = 0, osreq = 0, match_en = 0;
  reg  [3:0]  dly = 4'h1;
  wire        e_rd, e_dn, c_srch, c_dn, c_mt, ack, p_en, ck_en, cl_en, ret, srst_n, slp, fail;
  wire [23:0] id_rec, dir;
  wire [1:0]  mode;
  integer     mismatches = 0, samples_checked = 0;
  always #20 mclk_i = ~mclk_i;
  board_mode_sequencer #(.HOLD_CYCLES(20), .ACK_TIMEOUT(50)) dut (.mclk_i(mclk_i),
    .reset_n_i(reset_n_i), .power_applied_i(pwr), .onoff_btn_i(btn), .hw_reset_btn_i(hrst),
    .os_pwrdn_req_i(osreq), .eeprom_rd_o(e_rd), .eeprom_done_i(e_dn),
    .board_identity_number_i(id_rec[23:8]), .board_rev_i(id_rec[7:0]), .card_search_o(c_srch),
    .card_dir_name_o(dir), .card_done_i(c_dn), .card_match_i(c_mt), .board_power_en_o(p_en),
    .clocks_en_o(ck_en), .cluster_power_en_o(cl_en), .retention_en_o(ret),
    .sys_reset_n_o(srst_n), .cluster_sleep_req_o(slp), .cluster_ack_i(ack),
    .config_fail_o(fail), .board_mode_o(mode));
  board_partner far (.mclk_i(mclk_i), .eeprom_rd_i(e_rd), .card_search_i(c_srch),
    .mode_i(mode), .match_en_i(match_en), .dly_i(dly), .eeprom_done_o(e_dn), .id_rec_o(id_rec),
    .card_done_o(c_dn), .card_match_o(c_mt), .cluster_ack_o(ack));
  task stop_test; begin
    $display("mismatches %0d, samples_checked %0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  end endtask
  task check(input [23:0] seen, input [23:0] exp); begin
    samples_checked = samples_checked + 1;
    if (seen !== exp) begin
      mismatches = mismatches + 1;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  end endtask
  task wait_mode(input [1:0] m); integer i; begin
    for (i = 0; i < 300 && mode !== m; i = i + 1) @(negedge mclk_i);
    if (mode !== m) begin
      mismatches = mismatches + 1;
      $display("unexpected at %0t: mode wait ran out", $time);
      stop_test;
    end
  end endtask
  task press(input integer n); begin
    btn = 1;
    repeat (n) @(negedge mclk_i);
    btn = 0;
    @(negedge mclk_i);
  end endtask
  task no_match; begin
    pwr = 1;
    wait_mode(2'h3);
    check({e_rd, c_srch}, 2'h2);
    wait_mode(2'h0);
    check({fail, p_en}, 2'h2);
  end endtask
  task slow_powerup; begin
    match_en = 1;
    dly = 4'h6;
    press(3);
    osreq = 1;
    @(negedge mclk_i);
    osreq = 0;
    wait_mode(2'h1);
    check(dir, 24'h1a2b3c);
    check({p_en, ck_en, cl_en, srst_n}, 4'hf);
    repeat (10) @(negedge mclk_i);
    check(mode, 2'h1);
  end endtask
  task sleep_wake; begin
    dly = 4'h1;
    press(3);
    check({slp, mode}, 3'h7);
    wait_mode(2'h2);
    check({ret, cl_en}, 2'h2);
    press(3);
    wait_mode(2'h1);
    check({ret, cl_en}, 2'h1);
  end endtask
  task sleep_then_pd; begin
    press(3);
    wait_mode(2'h2);
    osreq = 1;
    @(negedge mclk_i);
    osreq = 0;
    wait_mode(2'h1);
    wait_mode(2'h0);
    check(p_en, 1'b0);
  end endtask
  task long_and_hw; begin
    press(3);
    wait_mode(2'h1);
    press(30);
    wait_mode(2'h0);
    check(ret, 1'b0);
    press(3);
    wait_mode(2'h1);
    hrst = 1;
    @(negedge mclk_i);
    hrst = 0;
    wait_mode(2'h0);
    check(srst_n, 1'b0);
  end endtask
  initial begin
    repeat (20) @(negedge mclk_i);
    reset_n_i = 1;
    no_match;
    slow_powerup;
    sleep_wake;
    sleep_then_pd;
    long_and_hw;
    stop_test;
  end
endmodule // tb
